// file: rtl/cri_cfg.svh
`ifndef CRI_CFG_SVH
`define CRI_CFG_SVH

// bus framing
`define CRI_TARGET_ADDR  7'h6B
`define CRI_BIT_LAST     4'h7
`define CRI_BIT_DONE     4'h8

// register pointers
`define CRI_PTR_IN       8'h00
`define CRI_PTR_CHG      8'h01
`define CRI_PTR_PREFAULT 8'h08
`define CRI_PTR_FAULT    8'h09
`define CRI_PTR_POSTFLT  8'h0A
`define CRI_PTR_LAST     8'h0B
`define CRI_PTR_OVER     8'h0C
`define CRI_PTR_ONE      8'h01
`define CRI_IDX_IN       4'h0
`define CRI_IDX_CHG      4'h1
`define CRI_NREGS        12
`define CRI_READ_FILL    8'hFF

// reset values and watchdog-reset masks
`define CRI_IN_RST       8'h17
`define CRI_CHG_RST      8'h1A
`define CRI_GEN_RST      8'h00
`define CRI_IN_WD_MASK   8'h80
`define CRI_CHG_WD_MASK  8'h70

// input control fields
`define CRI_HIZ_BIT      7
`define CRI_STAT_HI      6
`define CRI_STAT_LO      5
`define CRI_ILIM_HI      4
`define CRI_ILIM_LO      0
`define CRI_STAT_FLOAT   2'h3
`define CRI_ILIM_500MA   5'h04
`define CRI_ILIM_2A4     5'h17

// charge and boost control fields
`define CRI_LL_BIT       7
`define CRI_KICK_BIT     6
`define CRI_BOOST_BIT    5
`define CRI_CHGEN_BIT    4
`define CRI_VSYS_HI      3
`define CRI_VSYS_LO      1
`define CRI_VBST_BIT     0

// fault register layout
`define CRI_TS_W         3
`define CRI_LAT_W        5

`endif

// file: rtl/cri_pkg.sv
`default_nettype none

package cri_pkg;

   typedef enum logic [2:0] {
      ST_IDLE     = 3'b000,
      ST_RX       = 3'b001,
      ST_WAIT_ACK = 3'b010,
      ST_ACK_OUT  = 3'b011,
      ST_TX       = 3'b100,
      ST_ACK_IN   = 3'b101
   } cri_state_t;

   typedef enum logic [1:0] {
      KD_ADDR = 2'b00,
      KD_PTR  = 2'b01,
      KD_DATA = 2'b10
   } cri_kind_t;

endpackage

`default_nettype wire

// file: rtl/cri_sync.sv
`timescale 1ns/100ps
`default_nettype none

module cri_sync #(
   parameter int W = 1
) (
   input  wire logic         ref_clk_i,
   input  wire logic         sys_rst_i,
   input  wire logic [W-1:0] async_i,
   input  wire logic [W-1:0] rst_val_i,
   output logic      [W-1:0] sync_o
);

   logic [W-1:0] meta_reg;
   logic [W-1:0] sync_reg;

   // reset value comes in as a port but is only loaded on a clocked edge
   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         meta_reg <= rst_val_i;
         sync_reg <= rst_val_i;
      end else begin
         meta_reg <= async_i;
         sync_reg <= meta_reg;
      end
   end

   assign sync_o = sync_reg;

endmodule

`default_nettype wire

// file: rtl/cri_top.sv
// Overview of operation
// - each byte gets ninth-clock acknowledge slot
// - sender releases; receiver holds data low
// - first byte: 7-bit address plus direction
// - answer only our target address
// - undefined register pointer: not-acknowledge, idle
// - burst access auto-increments first to last, stepping over the fault register
// - fault register latches, read reloads live
// - thermistor fault field always live
// - fault register single byte only
// - input current field, power-on 10111
// - source detection loads current limit
// - status control 11 floats status pin
// - watchdog kick restarts timer, self-clears
// - boost enable overrides charging
// - charge needs pin low and bit
// - minimum system voltage code field
// - boost falling battery threshold select
// - reads above last register give FF
// - standard and fast mode rates
`timescale 1ns/100ps
`default_nettype none
`include "cri_cfg.svh"

module cri_top (
   input  wire logic                  ref_clk_i,
   input  wire logic                  sys_rst_i,
   input  wire logic                  reg_rst_i,
   input  wire logic                  wd_expire_i,
   input  wire logic                  scl_i,
   input  wire logic                  sda_i,
   input  wire logic                  psel_i,
   input  wire logic                  ce_n_i,
   input  wire logic [`CRI_TS_W-1:0]  ts_fault_i,
   input  wire logic [`CRI_LAT_W-1:0] fault_i,
   input  wire logic                  src_det_done_i,
   output logic                       sda_o,
   output logic                       sda_oe_o,
   output logic                       stat_float_o,
   output logic                       hiz_o,
   output logic                       light_load_dis_o,
   output logic [4:0]                 ilim_o,
   output logic                       wd_restart_o,
   output logic                       boost_en_o,
   output logic                       charge_en_o,
   output logic [2:0]                 min_sys_o,
   output logic                       boost_low_sel_o
);

   localparam int SW = 4 + `CRI_TS_W;

   logic [SW-1:0]          sync_in;
   logic [SW-1:0]          sync_rst;
   logic [SW-1:0]          sync_out;
   logic                   scl_s;
   logic                   sda_s;
   logic                   psel_s;
   logic                   ce_n_s;
   logic [`CRI_TS_W-1:0]   ts_s;
   logic                   scl_d_reg;
   logic                   sda_d_reg;

   // 100 MHz sampling leaves ample margin at 400 kbit/s
   assign sync_in  = {scl_i, sda_i, psel_i, ce_n_i, ts_fault_i};
   assign sync_rst = {1'b1, 1'b1, 1'b0, 1'b1, {`CRI_TS_W{1'b0}}};

   cri_sync #(.W(SW)) u_sync (
      .ref_clk_i (ref_clk_i),
      .sys_rst_i (sys_rst_i),
      .async_i   (sync_in),
      .rst_val_i (sync_rst),
      .sync_o    (sync_out)
   );

   assign scl_s  = sync_out[SW-1];
   assign sda_s  = sync_out[SW-2];
   assign psel_s = sync_out[SW-3];
   assign ce_n_s = sync_out[SW-4];
   assign ts_s   = sync_out[`CRI_TS_W-1:0];

   logic scl_rise;
   logic scl_fall;
   logic start_cond;
   logic stop_cond;

   assign scl_rise   = scl_s & ~scl_d_reg;
   assign scl_fall   = ~scl_s & scl_d_reg;
   assign start_cond = scl_s & scl_d_reg & sda_d_reg & ~sda_s;
   assign stop_cond  = scl_s & scl_d_reg & ~sda_d_reg & sda_s;

   cri_pkg::cri_state_t    state_reg,  state_next;
   cri_pkg::cri_kind_t     kind_reg,   kind_next;
   logic [3:0]             cnt_reg,    cnt_next;
   logic [7:0]             shift_reg,  shift_next;
   logic [7:0]             ptr_reg,    ptr_next;
   logic                   rw_reg,     rw_next;
   logic                   oe_reg,     oe_next;
   logic [7:0]             regs_reg   [0:`CRI_NREGS-1];
   logic [7:0]             regs_next  [0:`CRI_NREGS-1];
   logic [`CRI_LAT_W-1:0]  fault_reg,  fault_next;
   logic                   kick_reg,   kick_next;
   logic                   chg_reg,    chg_next;
   logic                   float_reg,  float_next;
   logic                   wr_en;
   logic                   fault_rd;
   logic [7:0]             byte_in;
   logic [7:0]             rd_data;

   // burst stepping skips the fault register and parks past the end
   function automatic logic [7:0] cri_incr(input logic [7:0] p);
      if (p == `CRI_PTR_PREFAULT) begin
         cri_incr = `CRI_PTR_POSTFLT;
      end else if (p == `CRI_PTR_FAULT || p >= `CRI_PTR_LAST) begin
         cri_incr = `CRI_PTR_OVER;
      end else begin
         cri_incr = p + `CRI_PTR_ONE;
      end
   endfunction

   always_comb begin
      if (ptr_reg > `CRI_PTR_LAST) begin
         rd_data = `CRI_READ_FILL;
      end else if (ptr_reg == `CRI_PTR_FAULT) begin
         rd_data = {fault_reg, ts_s};
      end else begin
         rd_data = regs_reg[ptr_reg[3:0]];
      end
   end

   assign byte_in = {shift_reg[6:0], sda_s};

   always_comb begin
      state_next = state_reg;
      kind_next  = kind_reg;
      cnt_next   = cnt_reg;
      shift_next = shift_reg;
      ptr_next   = ptr_reg;
      rw_next    = rw_reg;
      oe_next    = oe_reg;
      wr_en      = 1'b0;
      fault_rd   = 1'b0;
      if (stop_cond) begin
         state_next = cri_pkg::ST_IDLE;
         oe_next    = 1'b0;
      end else if (start_cond) begin
         state_next = cri_pkg::ST_RX;
         kind_next  = cri_pkg::KD_ADDR;
         cnt_next   = 4'h0;
         oe_next    = 1'b0;
      end else begin
         unique case (state_reg)
            cri_pkg::ST_IDLE: begin
               oe_next = 1'b0;
            end
            cri_pkg::ST_RX: begin
               if (scl_rise) begin
                  shift_next = byte_in;
                  cnt_next   = cnt_reg + 4'h1;
                  if (cnt_reg == `CRI_BIT_LAST) begin
                     unique case (kind_reg)
                        cri_pkg::KD_ADDR: begin
                           if (byte_in[7:1] == `CRI_TARGET_ADDR) begin
                              rw_next    = byte_in[0];
                              state_next = cri_pkg::ST_WAIT_ACK;
                           end else begin
                              state_next = cri_pkg::ST_IDLE;
                           end
                        end
                        cri_pkg::KD_PTR: begin
                           if (byte_in <= `CRI_PTR_LAST) begin
                              ptr_next   = byte_in;
                              state_next = cri_pkg::ST_WAIT_ACK;
                           end else begin
                              state_next = cri_pkg::ST_IDLE;
                           end
                        end
                        default: begin
                           if (ptr_reg <= `CRI_PTR_LAST) begin
                              wr_en      = 1'b1;
                              ptr_next   = cri_incr(ptr_reg);
                              state_next = cri_pkg::ST_WAIT_ACK;
                           end else begin
                              state_next = cri_pkg::ST_IDLE;
                           end
                        end
                     endcase
                  end
               end
            end
            cri_pkg::ST_WAIT_ACK: begin
               if (scl_fall) begin
                  oe_next    = 1'b1;
                  state_next = cri_pkg::ST_ACK_OUT;
               end
            end
            cri_pkg::ST_ACK_OUT: begin
               if (scl_fall) begin
                  cnt_next = 4'h0;
                  if (kind_reg == cri_pkg::KD_ADDR && rw_reg) begin
                     shift_next = rd_data;
                     oe_next    = ~rd_data[7];
                     fault_rd   = (ptr_reg == `CRI_PTR_FAULT);
                     ptr_next   = cri_incr(ptr_reg);
                     kind_next  = cri_pkg::KD_DATA;
                     state_next = cri_pkg::ST_TX;
                  end else begin
                     oe_next    = 1'b0;
                     kind_next  = (kind_reg == cri_pkg::KD_ADDR) ? cri_pkg::KD_PTR : cri_pkg::KD_DATA;
                     state_next = cri_pkg::ST_RX;
                  end
               end
            end
            cri_pkg::ST_TX: begin
               if (scl_rise) begin
                  cnt_next = cnt_reg + 4'h1;
               end else if (scl_fall) begin
                  if (cnt_reg == `CRI_BIT_DONE) begin
                     oe_next    = 1'b0;
                     state_next = cri_pkg::ST_ACK_IN;
                  end else begin
                     shift_next = {shift_reg[6:0], 1'b0};
                     oe_next    = ~shift_reg[6];
                  end
               end
            end
            cri_pkg::ST_ACK_IN: begin
               if (scl_rise && sda_s) begin
                  state_next = cri_pkg::ST_IDLE;
               end else if (scl_fall) begin
                  cnt_next   = 4'h0;
                  shift_next = rd_data;
                  oe_next    = ~rd_data[7];
                  fault_rd   = (ptr_reg == `CRI_PTR_FAULT);
                  ptr_next   = cri_incr(ptr_reg);
                  state_next = cri_pkg::ST_TX;
               end
            end
            default: begin
               state_next = cri_pkg::ST_IDLE;
               oe_next    = 1'b0;
            end
         endcase
      end
   end

   always_comb begin
      for (int i = 0; i < `CRI_NREGS; i++) begin
         regs_next[i] = regs_reg[i];
      end
      // a fault arriving with the read is kept for the next read
      fault_next = fault_reg | fault_i;
      if (fault_rd) begin
         fault_next = fault_i;
      end
      kick_next = 1'b0;
      if (regs_reg[`CRI_IDX_CHG][`CRI_KICK_BIT]) begin
         kick_next = 1'b1;
         regs_next[`CRI_IDX_CHG][`CRI_KICK_BIT] = 1'b0;
      end
      if (wr_en && ptr_reg != `CRI_PTR_FAULT) begin
         regs_next[ptr_reg[3:0]] = shift_next;
      end
      if (src_det_done_i) begin
         regs_next[`CRI_IDX_IN][`CRI_ILIM_HI:`CRI_ILIM_LO] = psel_s ? `CRI_ILIM_500MA : `CRI_ILIM_2A4;
      end
      if (wd_expire_i) begin
         regs_next[`CRI_IDX_IN]  = (regs_next[`CRI_IDX_IN] & ~`CRI_IN_WD_MASK) | (`CRI_IN_RST & `CRI_IN_WD_MASK);
         regs_next[`CRI_IDX_CHG] = (regs_next[`CRI_IDX_CHG] & ~`CRI_CHG_WD_MASK) | (`CRI_CHG_RST & `CRI_CHG_WD_MASK);
      end
      if (reg_rst_i) begin
         for (int i = 0; i < `CRI_NREGS; i++) begin
            regs_next[i] = `CRI_GEN_RST;
         end
         regs_next[`CRI_IDX_IN]  = `CRI_IN_RST;
         regs_next[`CRI_IDX_CHG] = `CRI_CHG_RST;
      end
      chg_next   = ~ce_n_s & regs_reg[`CRI_IDX_CHG][`CRI_CHGEN_BIT]
                   & ~regs_reg[`CRI_IDX_CHG][`CRI_BOOST_BIT];
      float_next = (regs_reg[`CRI_IDX_IN][`CRI_STAT_HI:`CRI_STAT_LO] == `CRI_STAT_FLOAT);
   end

   always_ff @(posedge ref_clk_i) begin
      if (sys_rst_i) begin
         state_reg <= cri_pkg::ST_IDLE;
         kind_reg  <= cri_pkg::KD_ADDR;
         cnt_reg   <= 4'h0;
         shift_reg <= 8'h00;
         ptr_reg   <= `CRI_PTR_IN;
         rw_reg    <= 1'b0;
         oe_reg    <= 1'b0;
         scl_d_reg <= 1'b1;
         sda_d_reg <= 1'b1;
         fault_reg <= '0;
         kick_reg  <= 1'b0;
         chg_reg   <= 1'b0;
         float_reg <= 1'b0;
         for (int i = 0; i < `CRI_NREGS; i++) begin
            regs_reg[i] <= `CRI_GEN_RST;
         end
         regs_reg[`CRI_IDX_IN]  <= `CRI_IN_RST;
         regs_reg[`CRI_IDX_CHG] <= `CRI_CHG_RST;
      end else begin
         state_reg <= state_next;
         kind_reg  <= kind_next;
         cnt_reg   <= cnt_next;
         shift_reg <= shift_next;
         ptr_reg   <= ptr_next;
         rw_reg    <= rw_next;
         oe_reg    <= oe_next;
         scl_d_reg <= scl_s;
         sda_d_reg <= sda_s;
         fault_reg <= fault_next;
         kick_reg  <= kick_next;
         chg_reg   <= chg_next;
         float_reg <= float_next;
         for (int i = 0; i < `CRI_NREGS; i++) begin
            regs_reg[i] <= regs_next[i];
         end
      end
   end

   // open drain: only ever pull low
   assign sda_o            = 1'b0;
   assign sda_oe_o         = oe_reg;
   assign stat_float_o     = float_reg;
   assign hiz_o            = regs_reg[`CRI_IDX_IN][`CRI_HIZ_BIT];
   assign ilim_o           = regs_reg[`CRI_IDX_IN][`CRI_ILIM_HI:`CRI_ILIM_LO];
   assign light_load_dis_o = regs_reg[`CRI_IDX_CHG][`CRI_LL_BIT];
   assign wd_restart_o     = kick_reg;
   assign boost_en_o       = regs_reg[`CRI_IDX_CHG][`CRI_BOOST_BIT];
   assign charge_en_o      = chg_reg;
   assign min_sys_o        = regs_reg[`CRI_IDX_CHG][`CRI_VSYS_HI:`CRI_VSYS_LO];
   assign boost_low_sel_o  = regs_reg[`CRI_IDX_CHG][`CRI_VBST_BIT];

   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (sys_rst_i);

   sequence s_kick_seen;
      regs_reg[`CRI_IDX_CHG][`CRI_KICK_BIT] && !wr_en && !reg_rst_i;
   endsequence
   sequence s_kick_done;
      wd_restart_o && !regs_reg[`CRI_IDX_CHG][`CRI_KICK_BIT];
   endsequence

   a_ack_drive_low: assert property (state_reg == cri_pkg::ST_ACK_OUT |-> sda_oe_o)
      else $error("acknowledge slot not driven low");
   a_ack_release: assert property (state_reg == cri_pkg::ST_ACK_IN |-> !sda_oe_o)
      else $error("data line held during host acknowledge");
   a_addr_ignore: assert property (state_reg == cri_pkg::ST_RX && kind_reg == cri_pkg::KD_ADDR && scl_rise
      && cnt_reg == `CRI_BIT_LAST && byte_in[7:1] != `CRI_TARGET_ADDR && !start_cond && !stop_cond
      |=> state_reg == cri_pkg::ST_IDLE ##1 !sda_oe_o)
      else $error("foreign address answered");
   a_bad_ptr_idle: assert property (state_reg == cri_pkg::ST_RX && kind_reg == cri_pkg::KD_PTR && scl_rise
      && cnt_reg == `CRI_BIT_LAST && byte_in > `CRI_PTR_LAST && !start_cond && !stop_cond
      |=> state_reg == cri_pkg::ST_IDLE && !sda_oe_o)
      else $error("undefined pointer acknowledged");
   a_read_fill_ff: assert property (fault_rd == 1'b0 && state_next == cri_pkg::ST_TX
      && state_reg != cri_pkg::ST_TX && ptr_reg > `CRI_PTR_LAST |=> shift_reg == `CRI_READ_FILL)
      else $error("read past last register not FF");
   a_fault_reload: assert property (fault_rd |=> fault_reg == $past(fault_i))
      else $error("fault latch not reloaded after read");
   a_fault_sticky: assert property (!fault_rd && !$rose(sys_rst_i)
      |=> (fault_reg & $past(fault_reg)) == $past(fault_reg))
      else $error("latched fault lost without read");
   a_ts_live: assert property (fault_rd |=> shift_reg[`CRI_TS_W-1:0] == $past(ts_s))
      else $error("thermistor field not live");
   a_kick_clear: assert property (s_kick_seen |=> s_kick_done)
      else $error("watchdog kick not pulsed and cleared");
   a_boost_block: assert property (boost_en_o |=> !charge_en_o)
      else $error("charging while boost enabled");
   a_charge_gate: assert property (charge_en_o |-> !$past(ce_n_s)
      && $past(regs_reg[`CRI_IDX_CHG][`CRI_CHGEN_BIT]))
      else $error("charging without pin and bit");
   a_src_detect: assert property (src_det_done_i && !reg_rst_i && !wr_en && !wd_expire_i
      |=> ilim_o == ($past(psel_s) ? `CRI_ILIM_500MA : `CRI_ILIM_2A4))
      else $error("source detection did not load limit");
   a_stat_float: assert property (regs_reg[`CRI_IDX_IN][`CRI_STAT_HI:`CRI_STAT_LO] == `CRI_STAT_FLOAT
      |=> stat_float_o)
      else $error("status pin not floated");
   a_fault_no_burst: assert property (fault_rd |=> ptr_reg == `CRI_PTR_OVER)
      else $error("burst continued past fault register");

endmodule

`default_nettype wire

// file: tb/cri_host.sv
`timescale 1ns/100ps
`default_nettype none

module cri_host (
   input  wire logic ref_clk_i,
   input  wire logic sda_i,
   output logic      scl_o,
   output logic      sda_low_o
);
   initial begin
      scl_o     = 1'b1;
      sda_low_o = 1'b0;
   end

   task automatic tick(input int n);
      repeat (n) @(posedge ref_clk_i);
   endtask

   // a quarter of the 160 ns serial period is four reference clocks
   task automatic bit_io(input logic b, output logic r);
      tick(4);
      sda_low_o <= !b; // data only moves while the clock is low
      tick(4);
      scl_o <= 1'b1;
      tick(4);
      r = sda_i;
      tick(4);
      scl_o <= 1'b0;
   endtask

   // also serves as repeated start, so it releases the data line first
   task automatic start();
      tick(4);
      sda_low_o <= 1'b0;
      tick(4);
      scl_o <= 1'b1;
      tick(4);
      sda_low_o <= 1'b1;
      tick(4);
      scl_o <= 1'b0;
   endtask

   task automatic stop();
      tick(4);
      sda_low_o <= 1'b1;
      tick(4);
      scl_o <= 1'b1;
      tick(4);
      sda_low_o <= 1'b0;
      tick(8);
   endtask

   // a is what goes into the ninth slot, 1 leaves the line released
   task automatic byte_io(input logic [7:0] d, input logic a, output logic [7:0] q, output logic n);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_io(d[i], r);
         q[i] = r;
      end
      bit_io(a, n);
   endtask
endmodule

`default_nettype wire

// file: tb/tb_charger_i2c_register_interface.sv
`timescale 1ns/100ps
`default_nettype none

module tb_charger_i2c_register_interface;
   logic        clk, rst, rrst, wde;
   logic        psel, cen_n, det;
   logic [2:0]  ts, msys;
   logic [4:0]  flt, ilim;
   logic        scl, hlow, sdaw, sdo, soe, sflt, hiz, lld, wdr, bst, chg, bls, n;
   logic [7:0]  mdl [12];
   logic [7:0]  fexp, q;
   logic [31:0] rnd = 32'h4921;
   int          fails = 0, compares = 0, kicks = 0, xkicks = 0;

   always #5 clk = !clk;
   // pull-up on the data wire, either party may pull it low
   assign sdaw = (hlow || (soe && !sdo)) ? 1'b0 : 1'b1;
   always @(posedge clk) if (wdr === 1'b1) kicks <= kicks + 1;

   cri_host host (.ref_clk_i(clk), .sda_i(sdaw), .scl_o(scl), .sda_low_o(hlow));

   cri_top DUT (
      .ref_clk_i(clk), .sys_rst_i(rst), .reg_rst_i(rrst), .wd_expire_i(wde), .scl_i(scl), .sda_i(sdaw),
      .psel_i(psel), .ce_n_i(cen_n), .ts_fault_i(ts), .fault_i(flt), .src_det_done_i(det), .sda_o(sdo),
      .sda_oe_o(soe), .stat_float_o(sflt), .hiz_o(hiz), .light_load_dis_o(lld), .ilim_o(ilim),
      .wd_restart_o(wdr), .boost_en_o(bst), .charge_en_o(chg), .min_sys_o(msys), .boost_low_sel_o(bls)
   );

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   function automatic logic [7:0] nxt(input logic [7:0] p);
      return (p == 8'h08) ? 8'h0A : (p == 8'h09 || p >= 8'h0B) ? 8'h0C : p + 8'h01;
   endfunction

   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      compares++;
      if (seen !== exp) begin
         fails++;
         $display("FAIL %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic summarize();
      $display("compares %0d fails %0d", compares, fails);
      if (fails == 0 && compares > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   task automatic adr(input logic [7:0] p);
      host.start();
      host.byte_io({7'h6B, 1'b0}, 1'b1, q, n);
      chk({7'h0, n}, 8'h00);
      host.byte_io(p, 1'b1, q, n);
      chk({7'h0, n}, {7'h0, p > 8'h0B});
   endtask

   task automatic wr(input logic [7:0] p, input logic [7:0] d[$]);
      adr(p);
      foreach (d[i]) begin
         host.byte_io(d[i], 1'b1, q, n);
         chk({7'h0, n}, 8'h00);
         if (p == 8'h01) begin
            xkicks += d[i][6];
            d[i][6] = 1'b0;
         end
         if (p != 8'h09)
            mdl[p[3:0]] = d[i];
         p = nxt(p);
      end
      host.stop();
      host.tick(8);
   endtask

   task automatic rd(input logic [7:0] p, input int cnt);
      adr(p);
      host.start();
      host.byte_io({7'h6B, 1'b1}, 1'b1, q, n);
      chk({7'h0, n}, 8'h00);
      for (int i = 0; i < cnt; i++) begin
         host.byte_io(8'hFF, i == cnt - 1, q, n);
         chk(q, p > 8'h0B ? 8'hFF : p == 8'h09 ? fexp : mdl[p[3:0]]);
         p = nxt(p);
      end
      host.stop();
      host.tick(8);
   endtask

   task automatic outs();
      host.tick(8);
      chk({hiz, sflt, 1'b0, ilim}, {mdl[0][7], &mdl[0][6:5], 1'b0, mdl[0][4:0]});
      chk({lld, 1'b0, bst, chg, msys, bls},
          {mdl[1][7], 1'b0, mdl[1][5], !cen_n & mdl[1][4] & !mdl[1][5], mdl[1][3:0]});
   endtask

   initial begin
      logic [7:0] wq[$];
      clk   = 1'b0;
      rst   = 1'b1;
      rrst  = 1'b0;
      wde   = 1'b0;
      psel  = 1'b0;
      cen_n = 1'b0;
      det   = 1'b0;
      ts    = 3'h0;
      flt   = 5'h00;
      mdl = '{0: 8'h17, 1: 8'h1A, default: 8'h00};
      repeat (12) @(posedge clk);
      rst <= 1'b0;
      host.tick(4);
      outs();
      rd(8'h00, 2);
      // a foreign address must get no acknowledge
      host.start();
      host.byte_io({7'h6A, 1'b0}, 1'b1, q, n);
      chk({7'h0, n}, 8'h01);
      host.stop();
      repeat (3) begin
         wq = {};
         repeat (4) begin
            rnd = lfsr(rnd);
            wq.push_back(rnd[7:0]);
         end
         cen_n <= rnd[9];
         ts <= rnd[12:10];
         wr(8'h00, wq);
         outs();
         rd(8'h00, 4);
      end
      chk(kicks[7:0], xkicks[7:0]);
      // random data may miss these, so float the status pin and enable boost with charging on purpose
      wq = {8'hE5, 8'h30};
      wr(8'h00, wq);
      outs();
      wq = {8'h3C, 8'h5A};
      wr(8'h08, wq);
      rd(8'h08, 3);
      rd(8'h0B, 2);
      wq = {8'hA5};
      wr(8'h09, wq);
      wq = {};
      wr(8'h0C, wq);
      // a short fault must survive until the first read only
      rnd = lfsr(rnd);
      flt <= rnd[4:0] | 5'h01;
      host.tick(3);
      flt <= 5'h00;
      fexp = {rnd[4:0] | 5'h01, ts};
      rd(8'h09, 1);
      fexp = {5'h00, ts};
      rd(8'h09, 1);
      for (int i = 0; i < 2; i++) begin
         psel <= !i[0];
         host.tick(6);
         det <= 1'b1;
         host.tick(1);
         det <= 1'b0;
         mdl[0][4:0] = i[0] ? 5'h17 : 5'h04;
         outs();
      end
      wde <= 1'b1;
      host.tick(1);
      wde <= 1'b0;
      mdl[0][7] = 1'b0;
      mdl[1][6:4] = 3'b001;
      outs();
      rd(8'h00, 2);
      rrst <= 1'b1;
      host.tick(1);
      rrst <= 1'b0;
      mdl = '{0: 8'h17, 1: 8'h1A, default: 8'h00};
      outs();
      rd(8'h00, 4);
      summarize();
   end

   // the whole sequence needs roughly a quarter of this span
   initial begin
      repeat (60000) @(posedge clk);
      fails++;
      summarize();
   end
endmodule

`default_nettype wire
